// >>> dma_defs.svh
// Register offsets, field positions, reset values and timing counts for
// the two-channel transfer controller.
// Assumes inclusion by bare name from the design file.
//
// Overview of operation
// - Three-bit mode selects single-step, burst, demand, single-transfer or off.
// - Word-size bit: byte units step pointers by 1, words step by 2.
// - Enable alone arms a channel; enable plus trigger starts memory copies.
// - Hardware clears enable at terminal count; requests ignored while clear.
// - Trigger acts only in memory modes with enable set; reads zero.
// - Destination step: 00/11 hold, 01 increment, 10 decrement.
// - Source step: same coding as destination step.
// - Pointers are three bytes with 20 used bits; top bits read zero.
// - Single-step: one start, then CPU slot and transfer alternate.
// - Burst: one start runs all transfers back to back.
// - Single-transfer: one transfer per request rising edge; at most one edge is held pending.
// - Demand: transfers continue while the request pin stays high.
// - Transfers end after the transfer made with the count at zero; the count is not decremented.
// - Interrupt blocking only during demand transfers or whole bursts.
// - Channel 0 wins; other requests wait; bursts finish first.
// - Acknowledge low only during I/O transfers, never memory copies.
// - Bus cycle is three states plus programmed waits.
// - Memory copy: source waits on read, destination waits on write.
// - Memory to I/O uses the larger of both wait counts.
// - I/O to memory uses the memory write wait count.
`ifndef DMA_DEFS_SVH
`define DMA_DEFS_SVH

// Word index inside a channel's block
`define REG_MODE      4'h0
`define REG_STEP      4'h1
`define REG_SRC_LOW   4'h2
`define REG_SRC_MID   4'h3
`define REG_SRC_HIGH  4'h4
`define REG_DST_LOW   4'h5
`define REG_DST_MID   4'h6
`define REG_DST_HIGH  4'h7
`define REG_COUNT     4'h8
`define REG_WAIT      4'h9
// Address bit choosing channel, and bit choosing the status word
`define ADR_CH_BIT    6
`define ADR_STAT_BIT  7

// Fields of channel_mode
`define F_MODE_HI     7
`define F_MODE_LO     5
`define F_WORD        4
`define F_EN          3
`define F_TRIG        2
// Fields of pointer_update_control and of the wait register
`define F_DST_HI      5
`define F_DST_LO      4
`define F_SRC_HI      1
`define F_SRC_LO      0

// Mode codes
`define M_STEP        3'h0
`define M_DEM_IN      3'h1
`define M_DEM_OUT     3'h2
`define M_BURST       3'h4
`define M_ONE_IN      3'h5
`define M_ONE_OUT     3'h6

// Baseline clock states of one bus cycle (ld takes one off for the timer); idle acknowledge levels
`define BASE_STATES   4'h3
`define ACK_IDLE      2'h3

`endif

// >>> dma_pkg.sv
// Types shared by the transfer controller: channel record, phase
// encoding and the whole-state record.
// Assumes no other package.
`default_nettype none
package dma_pkg;

   typedef struct packed {
      logic [2:0]  mode;
      logic        word;
      logic        en;
      logic [1:0]  dstep;
      logic [1:0]  sstep;
      logic [19:0] src;
      logic [19:0] dst;
      logic [15:0] cnt;
      logic [1:0]  wsrc;
      logic [1:0]  wdst;
      logic        pend;
      logic        run;
   } chan_t;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_READ  = 5'b00010,
      ST_WRITE = 5'b00100,
      ST_FLY   = 5'b01000,
      ST_GAP   = 5'b10000
   } phase_t;

   typedef struct packed {
      chan_t [1:0] ch;
      phase_t      ph;
      logic        cur;
      logic [3:0]  tmr;
      logic [1:0]  rq_a;
      logic [1:0]  rq_b;
      logic [1:0]  rq_c;
      logic        dp_wr;
      logic        dp_rd;
      logic [7:0]  dp_adr;
      logic        ready;
      logic        resp;
      logic [31:0] rdata;
      logic [19:0] maddr;
      logic [15:0] mwdata;
      logic        mrd;
      logic        mwr;
      logic        mword;
      logic [1:0]  ack_n;
      logic        irq_block;
   } dma_t;

endpackage
`default_nettype wire

// >>> dma_ctrl.sv
// Two-channel transfer controller with an AHB-Lite register slave and a
// simple single-master memory port.
// Assumes mem_rdata is valid on the last state of a read cycle and that
// transfer_request_pin comes from outside the clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "dma_defs.svh"

module dma_ctrl (
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [31:0]            hrdata,
   input  wire logic [1:0]        transfer_request_pin,
   output logic [1:0]             transfer_acknowledge_n,
   output logic [19:0]            mem_addr,
   output logic [15:0]            mem_wdata,
   input  wire logic [15:0]       mem_rdata,
   output logic                   mem_read,
   output logic                   mem_write,
   output logic                   mem_word,
   output logic                   irq_block
);
   import dma_pkg::*;

   dma_t q;
   dma_t n;
   logic [1:0] go;

   ////////////////////////////////////////////////////////////////////////
   // Mode decoding
   function automatic logic is_mm(input logic [2:0] m);
      return (m == `M_STEP) || (m == `M_BURST);
   endfunction

   function automatic logic is_dem(input logic [2:0] m);
      return (m == `M_DEM_IN) || (m == `M_DEM_OUT);
   endfunction

   function automatic logic is_one(input logic [2:0] m);
      return (m == `M_ONE_IN) || (m == `M_ONE_OUT);
   endfunction

   // I/O-to-memory codes both have the low mode bit set
   function automatic logic is_in(input logic [2:0] m);
      return (m == `M_DEM_IN) || (m == `M_ONE_IN);
   endfunction

   // Channel wants the bus; a cleared enable masks every request
   function automatic logic wants(input chan_t c, input logic lvl);
      return c.en && (is_mm(c.mode) || is_dem(c.mode) || is_one(c.mode))
         && (c.run || c.pend || (is_dem(c.mode) && lvl));
   endfunction

   // Pointer step by byte or word, up, down or held
   function automatic logic [19:0] step_ptr(input logic [19:0] p,
                                            input logic [1:0] f,
                                            input logic w);
      logic [19:0] d;
      d = {18'h0, w, ~w};
      case (f)
         2'b01:   return p + d;
         2'b10:   return p - d;
         default: return p;
      endcase
   endfunction

   // Timer load for a bus cycle of baseline states plus waits
   function automatic logic [3:0] ld(input logic [1:0] w);
      return (`BASE_STATES - 4'h1) + {2'h0, w};
   endfunction

   // Register read decode; pointer high bytes show only the used bits
   function automatic logic [31:0] rd_reg(input dma_t s,
                                          input logic [7:0] a);
      chan_t c;
      c = s.ch[a[`ADR_CH_BIT]];
      rd_reg = 32'h0;
      if (a[`ADR_STAT_BIT]) begin
         rd_reg = {27'h0, s.ch[1].run, s.ch[1].en, s.ch[0].run,
                   s.ch[0].en, (s.ph != ST_IDLE)};
      end else begin
         case (a[5:2])
            `REG_MODE:     rd_reg = {24'h0, c.mode, c.word, c.en, 3'h0};
            `REG_STEP:     rd_reg = {26'h0, c.dstep, 2'h0, c.sstep};
            `REG_SRC_LOW:  rd_reg = {24'h0, c.src[7:0]};
            `REG_SRC_MID:  rd_reg = {24'h0, c.src[15:8]};
            `REG_SRC_HIGH: rd_reg = {28'h0, c.src[19:16]};
            `REG_DST_LOW:  rd_reg = {24'h0, c.dst[7:0]};
            `REG_DST_MID:  rd_reg = {24'h0, c.dst[15:8]};
            `REG_DST_HIGH: rd_reg = {28'h0, c.dst[19:16]};
            `REG_COUNT:    rd_reg = {16'h0, c.cnt};
            `REG_WAIT:     rd_reg = {26'h0, c.wdst, 2'h0, c.wsrc};
            default:       rd_reg = 32'h0;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Request qualifiers seen by the arbiter
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         go[i] = wants(q.ch[i], q.rq_b[i]);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Next-state: engine first, request capture and software last so that
   // a set landing with an engine clear is kept
   always_comb begin
      logic       sel;
      logic       c;
      logic [1:0] wmax;
      chan_t      k;
      sel  = 1'b0;
      c    = q.cur;
      wmax = 2'h0;
      k    = q.ch[q.cur];
      n    = q;
      n.rq_a = transfer_request_pin;
      n.rq_b = q.rq_a;
      n.rq_c = q.rq_b;

      case (q.ph)
         ST_IDLE: begin
            // A running burst keeps the bus until its count runs out
            if (q.ch[q.cur].run && q.ch[q.cur].mode == `M_BURST
                && go[q.cur]) begin
               sel = 1'b1;
            end else if (go[0]) begin
               sel = 1'b1;
               c   = 1'b0;
            end else if (go[1]) begin
               sel = 1'b1;
               c   = 1'b1;
            end
            if (sel) begin
               k = q.ch[c];
               n.cur = c;
               n.ch[c].pend = 1'b0;
               n.mword = k.word;
               if (is_mm(k.mode)) begin
                  n.ch[c].run = 1'b1;
                  n.ph = ST_READ;
                  n.maddr = k.src;
                  n.mrd = 1'b1;
                  n.tmr = ld(k.wsrc);
               end else begin
                  wmax = (k.wsrc > k.wdst) ? k.wsrc : k.wdst;
                  n.ph = ST_FLY;
                  n.ack_n[c] = 1'b0;
                  n.maddr = is_in(k.mode) ? k.dst : k.src;
                  n.mwr = is_in(k.mode);
                  n.mrd = ~is_in(k.mode);
                  n.tmr = is_in(k.mode) ? ld(k.wdst) : ld(wmax);
               end
            end
         end
         ST_READ: begin
            if (q.tmr == 4'h0) begin
               n.mwdata = mem_rdata;
               n.mrd = 1'b0;
               n.mwr = 1'b1;
               n.maddr = k.dst;
               n.tmr = ld(k.wdst);
               n.ph = ST_WRITE;
            end else begin
               n.tmr = q.tmr - 4'h1;
            end
         end
         ST_WRITE, ST_FLY: begin
            if (q.tmr == 4'h0) begin
               n.mrd = 1'b0;
               n.mwr = 1'b0;
               n.ack_n = `ACK_IDLE;
               n.ch[q.cur].src = step_ptr(k.src, k.sstep, k.word);
               n.ch[q.cur].dst = step_ptr(k.dst, k.dstep, k.word);
               n.ph = ST_IDLE;
               if (k.cnt == 16'h0) begin
                  n.ch[q.cur].en = 1'b0;
                  n.ch[q.cur].run = 1'b0;
               end else begin
                  n.ch[q.cur].cnt = k.cnt - 16'h1;
                  // CPU gets one bus cycle before the next step
                  if (k.mode == `M_STEP) begin
                     n.ph = ST_GAP;
                     n.tmr = ld(2'h0);
                  end
               end
            end else begin
               n.tmr = q.tmr - 4'h1;
            end
         end
         ST_GAP: begin
            if (q.tmr == 4'h0) begin
               n.ph = ST_IDLE;
            end else begin
               n.tmr = q.tmr - 4'h1;
            end
         end
         default: begin
            n.ph = ST_IDLE;
         end
      endcase

      // Rising request edges latch a start; set beats the arbiter's clear
      for (int i = 0; i < 2; i++) begin
         if (q.ch[i].en && q.rq_b[i] && !q.rq_c[i]
             && (is_mm(q.ch[i].mode) || is_one(q.ch[i].mode))) begin
            n.ch[i].pend = 1'b1;
         end
      end

      // Register writes, data phase of the previous transfer
      if (q.dp_wr && !q.dp_adr[`ADR_STAT_BIT]) begin
         c = q.dp_adr[`ADR_CH_BIT];
         case (q.dp_adr[5:2])
            `REG_MODE: begin
               n.ch[c].mode = hwdata[`F_MODE_HI:`F_MODE_LO];
               n.ch[c].word = hwdata[`F_WORD];
               n.ch[c].en   = hwdata[`F_EN];
               if (!hwdata[`F_EN]) begin
                  n.ch[c].run  = 1'b0;
                  n.ch[c].pend = 1'b0;
               end
               // Trigger is a strobe, never stored
               if (hwdata[`F_TRIG] && hwdata[`F_EN]
                   && is_mm(hwdata[`F_MODE_HI:`F_MODE_LO])) begin
                  n.ch[c].pend = 1'b1;
               end
            end
            `REG_STEP: begin
               n.ch[c].dstep = hwdata[`F_DST_HI:`F_DST_LO];
               n.ch[c].sstep = hwdata[`F_SRC_HI:`F_SRC_LO];
            end
            `REG_SRC_LOW:  n.ch[c].src[7:0]   = hwdata[7:0];
            `REG_SRC_MID:  n.ch[c].src[15:8]  = hwdata[7:0];
            `REG_SRC_HIGH: n.ch[c].src[19:16] = hwdata[3:0];
            `REG_DST_LOW:  n.ch[c].dst[7:0]   = hwdata[7:0];
            `REG_DST_MID:  n.ch[c].dst[15:8]  = hwdata[7:0];
            `REG_DST_HIGH: n.ch[c].dst[19:16] = hwdata[3:0];
            `REG_COUNT:    n.ch[c].cnt        = hwdata[15:0];
            `REG_WAIT: begin
               n.ch[c].wdst = hwdata[`F_DST_HI:`F_DST_LO];
               n.ch[c].wsrc = hwdata[`F_SRC_HI:`F_SRC_LO];
            end
            default: ;
         endcase
      end

      // Reads answer one cycle late so a write just before is visible
      n.dp_wr = 1'b0;
      if (q.dp_rd) begin
         n.rdata = rd_reg(q, q.dp_adr);
         n.ready = 1'b1;
         n.dp_rd = 1'b0;
      end
      if (hsel && htrans[1] && hready) begin
         n.dp_adr = haddr[7:0];
         n.dp_wr  = hwrite;
         n.dp_rd  = ~hwrite;
         n.ready  = hwrite;
      end

      // CPU interrupts held off during bursts and demand transfers
      n.irq_block = (n.ph != ST_IDLE && n.ph != ST_GAP
                     && is_dem(n.ch[n.cur].mode))
                    || (n.ch[n.cur].run && n.ch[n.cur].mode == `M_BURST);
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q       <= '0;
         q.ph    <= ST_IDLE;
         q.ready <= 1'b1;
         q.ack_n <= `ACK_IDLE;
      end else begin
         q <= n;
      end
   end

   // Outputs straight from the state register
   assign hreadyout              = q.ready;
   assign hresp                  = q.resp;
   assign hrdata                 = q.rdata;
   assign transfer_acknowledge_n = q.ack_n;
   assign mem_addr               = q.maddr;
   assign mem_wdata              = q.mwdata;
   assign mem_read               = q.mrd;
   assign mem_write              = q.mwr;
   assign mem_word               = q.mword;
   assign irq_block              = q.irq_block;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   logic xfer_end;
   assign xfer_end = (q.ph == ST_WRITE || q.ph == ST_FLY) && q.tmr == 4'h0;

   property p_trig_zero;
      q.dp_rd && !q.dp_adr[`ADR_STAT_BIT] && q.dp_adr[5:2] == `REG_MODE
      |=> hreadyout && !hrdata[`F_TRIG];
   endproperty
   a_trig_zero: assert property (p_trig_zero)
      else $error("trigger bit read back as one");

   property p_high_zero;
      q.dp_rd && !q.dp_adr[`ADR_STAT_BIT]
      && q.dp_adr[5:2] == `REG_SRC_HIGH |=> hrdata[31:4] == 28'h0;
   endproperty
   a_high_zero: assert property (p_high_zero)
      else $error("pointer high byte shows unused bits");

   property p_ack_io;
      transfer_acknowledge_n != `ACK_IDLE |-> q.ph == ST_FLY;
   endproperty
   a_ack_io: assert property (p_ack_io)
      else $error("acknowledge low outside an I/O transfer");

   property p_len;
      $rose(mem_read) |-> mem_read [*3];
   endproperty
   a_len: assert property (p_len)
      else $error("bus cycle shorter than three states");

   property p_rd_wait;
      q.ph == ST_IDLE && n.ph == ST_READ
      |=> q.tmr == 4'h2 + {2'h0, q.ch[q.cur].wsrc};
   endproperty
   a_rd_wait: assert property (p_rd_wait)
      else $error("read cycle not using source wait states");

   property p_tc;
      xfer_end && q.ch[q.cur].cnt == 16'h0 && !q.dp_wr
      |=> !q.ch[$past(q.cur)].en;
   endproperty
   a_tc: assert property (p_tc)
      else $error("enable not cleared at terminal count");

   property p_gap;
      xfer_end && q.ch[q.cur].mode == `M_STEP && q.ch[q.cur].cnt != 16'h0
      |=> q.ph == ST_GAP [*3] ##1 q.ph == ST_IDLE;
   endproperty
   a_gap: assert property (p_gap)
      else $error("single-step did not yield a CPU slot");

   property p_burst;
      xfer_end && q.ch[q.cur].mode == `M_BURST && q.ch[q.cur].cnt != 16'h0
      && !q.dp_wr |=> q.ph == ST_IDLE ##1 q.ph == ST_READ;
   endproperty
   a_burst: assert property (p_burst)
      else $error("burst transfers not back to back");

   property p_prio;
      q.ph == ST_IDLE && go[0]
      && !(q.ch[1].run && q.ch[1].mode == `M_BURST) |=> !q.cur;
   endproperty
   a_prio: assert property (p_prio)
      else $error("channel 0 lost arbitration");

   property p_ignore;
      q.ph == ST_IDLE && !q.ch[0].en && !q.ch[1].en |=> q.ph == ST_IDLE;
   endproperty
   a_ignore: assert property (p_ignore)
      else $error("transfer started on a disabled channel");

   property p_irq;
      q.ph == ST_FLY && is_dem(q.ch[q.cur].mode) |-> irq_block;
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupts not held off in demand transfer");

   c_burst_end: cover property (xfer_end && q.ch[q.cur].mode == `M_BURST
                                && q.ch[q.cur].cnt == 16'h0);
   c_fly:       cover property (q.ph == ST_FLY && transfer_acknowledge_n[1]
                                == 1'b0);
   c_gap:       cover property (q.ph == ST_GAP);
   c_demand:    cover property (irq_block && q.ph == ST_FLY);

endmodule
`default_nettype wire

// >>> dma_io_model.sv
// I/O peripheral and memory seen from the transfer controller's far side.
// Assumes the bench loads a per-channel demand count through load/need_in.
`timescale 1ns/100ps
`default_nettype none
module dma_io_model (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic [1:0]  load,
   input  wire logic [3:0]  need_in,
   input  wire logic [1:0]  transfer_acknowledge_n,
   output logic      [1:0]  transfer_request_pin,
   input  wire logic [19:0] mem_addr,
   input  wire logic        mem_read,
   output logic      [15:0] mem_rdata
);
   logic [1:0][3:0] need_q;
   logic [1:0]      ack_q;
   ////////////////////////////////////////////////////////////////////////
   // Request stays high while data is wanted; each acknowledge uses one
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         need_q <= '0;
         ack_q  <= 2'h3;
      end else begin
         ack_q <= transfer_acknowledge_n;
         for (int c = 0; c < 2; c++) begin
            if (load[c])
               need_q[c] <= need_in;
            else if (ack_q[c] && !transfer_acknowledge_n[c] && need_q[c] != 0)
               need_q[c] <= need_q[c] - 4'h1;
         end
      end
   end
   assign transfer_request_pin = {need_q[1] != 0, need_q[0] != 0};
   // Unselected memory shows the inverse so a stale sample cannot pass
   assign mem_rdata = mem_read ? (mem_addr[15:0] ^ 16'h5a5a)
                               : ~(mem_addr[15:0] ^ 16'h5a5a);
endmodule
`default_nettype wire

// >>> dual_channel_dma_controller_tb.sv
// Self-checking bench for the two-channel transfer controller.
// Assumes dma_ctrl, dma_pkg and the I/O model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module dual_channel_dma_controller_tb;
   import dma_pkg::*;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rs;
   logic [1:0]  htrans = '0, req, ack_n, load = '0;
   logic [2:0]  hsize = 3'h2;
   logic [3:0]  need_in = '0;
   logic        hreadyout, hresp, mem_read, mem_write, mem_word, irq_block;
   logic [19:0] mem_addr;
   logic [15:0] mem_wdata, mem_rdata;
   int          err_count = 0, checked = 0, rd_n, wr_n, ak_n;
   int          rd_len, wr_len, ak_len, acks[2];
   logic        irq_seen;
   logic [35:0] wq[$];
   int          aq[$];
   always #12.5 hclk = ~hclk;
   dma_ctrl dma_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .transfer_request_pin(req),
      .transfer_acknowledge_n(ack_n), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_read(mem_read),
      .mem_write(mem_write), .mem_word(mem_word), .irq_block(irq_block));
   dma_io_model dma_io_model_i (.hclk(hclk), .hresetn(hresetn),
      .load(load), .need_in(need_in), .transfer_acknowledge_n(ack_n),
      .transfer_request_pin(req), .mem_addr(mem_addr),
      .mem_read(mem_read), .mem_rdata(mem_rdata));
   ////////////////////////////////////////////////////////////////////////
   // Monitor on the falling edge, where every registered output is settled
   always @(negedge hclk) begin
      if (mem_read) begin
         rd_n++;
      end else if (rd_n > 0) begin
         rd_len = rd_n;
         rd_n = 0;
      end
      if (mem_write && wr_n == 0) wq.push_back({mem_addr, mem_wdata});
      if (mem_write) begin
         wr_n++;
      end else if (wr_n > 0) begin
         wr_len = wr_n;
         wr_n = 0;
      end
      for (int c = 0; c < 2; c++) begin
         if (!ack_n[c] && ak_n == 0) begin
            acks[c]++;
            aq.push_back(c);
         end
      end
      if (ack_n !== 2'h3) begin
         ak_n++;
      end else if (ak_n > 0) begin
         ak_len = ak_n;
         ak_n = 0;
      end
      irq_seen |= irq_block;
   end
   ////////////////////////////////////////////////////////////////////////
   task final_report();
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task to();
      err_count++;
      $display("ERROR %0t timeout", $time);
      final_report();
   endtask
   task chk(input logic [35:0] g, input logic [35:0] e);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   endtask
   // Waits for hready high; capture at the falling edge avoids a race
   task wt();
      int n;
      n = 0;
      @(negedge hclk);
      while (hreadyout !== 1'b1) begin
         if (++n > 20) to();
         @(negedge hclk);
      end
      rs = hrdata;
      @(posedge hclk);
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
      wt();
      hsel <= 0; htrans <= 2'h0; hwdata <= d;
      wt();
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1, a, d);
   endtask
   task rc(input logic [7:0] a, input logic [31:0] e);
      bus(0, a, 0);
      chk(rs, e);
   endtask
   task cfg(input logic [7:0] b, input logic [7:0] st, input logic [19:0] s,
            input logic [19:0] d, input logic [15:0] n, input logic [7:0] w);
      wr(b + 8'h04, st); wr(b + 8'h08, s[7:0]); wr(b + 8'h0c, s[15:8]);
      wr(b + 8'h10, s[19:16]); wr(b + 8'h14, d[7:0]); wr(b + 8'h18, d[15:8]);
      wr(b + 8'h1c, d[19:16]); wr(b + 8'h20, n); wr(b + 8'h24, w);
      wq.delete(); aq.delete(); acks = '{0, 0}; irq_seen = 0;
      // Stale lengths from an earlier scenario must not pass a check
      rd_len = 0;
      wr_len = 0;
      ak_len = 0;
   endtask
   task ld(input logic [1:0] m, input logic [3:0] n);
      @(posedge hclk);
      need_in <= n; load <= m;
      @(posedge hclk);
      load <= 2'h0;
   endtask
   // Polls status until two reads in a row show no bus cycle and no run;
   // a single read could land in the one idle clock between transfers
   task idle();
      int n;
      int quiet;
      n = 0;
      quiet = 0;
      repeat (6) @(posedge hclk);
      while (quiet < 2) begin
         if (++n > 200) to();
         bus(0, 8'h80, 0);
         if ((rs[4:0] & 5'h15) === 5'h00)
            quiet++;
         else
            quiet = 0;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   task t_regs();
      rc(8'h00, 0);
      rc(8'h80, 0);
      chk(hresp, 0);
      wr(8'h00, 8'h94);
      rc(8'h00, 8'h90);
      wr(8'h10, 8'hff);
      rc(8'h10, 8'h0f);
      rc(8'h3c, 0);
      wr(8'h00, 0);
   endtask
   // Word burst, source up, destination down, distinct waits per phase
   task t_burst();
      cfg(8'h00, 8'h21, 20'h12340, 20'h0abc0, 2, 8'h21);
      wr(8'h00, 8'h9c);
      idle();
      chk(wq.size(), 3);
      for (int i = 0; i < 3; i++)
         chk(wq[i], {20'h0abc0 - 20'(2 * i),
                     16'h2340 + 16'(2 * i) ^ 16'h5a5a});
      chk(rd_len, 4);
      chk(wr_len, 5);
      chk(acks[0], 0);
      chk(irq_seen, 1);
      rc(8'h00, 8'h90);
      rc(8'h08, 8'h46);
      rc(8'h14, 8'hba);
   endtask
   // Byte single-step on channel 1, source held, destination up
   task t_step();
      cfg(8'h40, 8'h13, 20'h00010, 20'h00200, 1, 0);
      wr(8'h40, 8'h0c);
      idle();
      chk(wq.size(), 2);
      chk(wq[1][35:16], 20'h00201);
      chk(mem_word, 0);
      rc(8'h54, 8'h02);
      rc(8'h48, 8'h10);
      chk(irq_seen, 0);
      chk(rd_len, 3);
   endtask
   // Second request edge arrives while the first transfer is running
   task t_single();
      int n;
      cfg(8'h40, 8'h11, 20'h0, 20'h00300, 5, 8'h13);
      wr(8'h40, 8'hb8);
      ld(2'h2, 1);
      n = 0;
      while (ack_n[1] !== 1'b0) begin
         if (++n > 50) to();
         @(posedge hclk);
      end
      ld(2'h2, 1);
      idle();
      chk(acks[1], 2);
      chk(wr_len, 4);
      chk(ak_len, 4);
      chk(wq[1][35:16], 20'h00302);
      chk(irq_seen, 0);
      rc(8'h40, 8'hb8);
      wr(8'h40, 8'h78);
      ld(2'h2, 1);
      idle();
      // Nothing consumed that request; drop the pin so the next one rises
      ld(2'h2, 0);
      wr(8'h40, 8'hb0);
      ld(2'h2, 1);
      idle();
      ld(2'h2, 0);
      chk(acks[1], 2);
   endtask
   task t_demand();
      cfg(8'h00, 8'h01, 20'h00400, 20'h0, 20, 8'h12);
      wr(8'h00, 8'h48);
      ld(2'h1, 3);
      idle();
      chk(acks[0], 3);
      chk(rd_len, 5);
      chk(irq_seen, 1);
      rc(8'h08, 8'h03);
   endtask
   // Both channels request in the same cycle
   task t_prio();
      wr(8'h00, 8'hd8);
      wr(8'h40, 8'hb8);
      aq.delete(); acks = '{0, 0};
      ld(2'h3, 1);
      idle();
      chk(aq[0], 0);
      chk(acks[1], 1);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1;
      @(posedge hclk);
      t_regs();
      t_burst();
      t_step();
      t_single();
      t_demand();
      t_prio();
      final_report();
   end
endmodule
`default_nettype wire
